// ---- cpuitd_addr.sv ----
// operand address arithmetic for branch targets and register operands
`default_nettype none
module cpuitd_addr
  import cpuitd_pkg::*;
(
  input wire logic [15:0] instr_addr,
  input wire logic [1:0] instr_len,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1,
  input wire logic [7:0] operand2,
  input wire logic [1:0] bank_sel,
  output logic [15:0] next_pc,
  output logic [15:0] rel_target,
  output logic [15:0] abs_target,
  output logic [7:0] bank_reg_addr,
  output logic [7:0] ptr_reg_addr
);
  logic [7:0] disp;

  // address of the byte after this instruction
  assign next_pc = 16'(instr_addr + {14'h0000, instr_len});
  // three-byte branches carry the displacement in their last byte
  assign disp = (instr_len == CPUITD_L3) ? operand2 : operand1;
  assign rel_target = 16'(next_pc + {{8{disp[7]}}, disp});
  // page bits come from next_pc, so a page-end branch lands in the next page
  assign abs_target = {next_pc[15:CPUITD_PAGE_BITS], opcode[7:5], operand1};
  // register file address inside the active bank
  assign bank_reg_addr = {3'h0, bank_sel, opcode[2:0]};
  assign ptr_reg_addr = {3'h0, bank_sel, 2'h0, opcode[0]};
endmodule
`default_nettype wire

// ---- cpuitd_code_mem.sv ----
// program memory model feeding opcode and operand bytes to the decoder
`default_nettype none
module cpuitd_code_mem
(
  input wire logic [15:0] fetch_addr,
  input wire logic rd_en,
  output logic [7:0] byte0,
  output logic [7:0] byte1,
  output logic [7:0] byte2
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:65535];
  logic [15:0] addr1;
  logic [15:0] addr2;
  // operand fetch wraps at the top of code space
  assign addr1 = fetch_addr + 16'h0001;
  assign addr2 = fetch_addr + 16'h0002;
  // unread bus shows inverted bytes so stale data never passes for fresh
  assign byte0 = rd_en ? mem[fetch_addr] : ~mem[fetch_addr];
  assign byte1 = rd_en ? mem[addr1] : ~mem[addr1];
  assign byte2 = rd_en ? mem[addr2] : ~mem[addr2];
endmodule
`default_nettype wire

// ---- cpuitd_pkg.sv ----
// shared constants for the instruction length and timing decoder
`default_nettype none
package cpuitd_pkg;
  localparam int CPUITD_LEN_W = 2;
  localparam int CPUITD_CYC_W = 3;
  // clock figure, kept for reference by the bench
  localparam int CPUITD_CLK_PERIOD_NS = 5;
  // encoded lengths in bytes
  localparam logic [1:0] CPUITD_L1 = 2'h1;
  localparam logic [1:0] CPUITD_L2 = 2'h2;
  localparam logic [1:0] CPUITD_L3 = 2'h3;
  // execution times in clock cycles
  localparam logic [2:0] CPUITD_C1 = 3'h1;
  localparam logic [2:0] CPUITD_C2 = 3'h2;
  localparam logic [2:0] CPUITD_C3 = 3'h3;
  localparam logic [2:0] CPUITD_C4 = 3'h4;
  localparam logic [2:0] CPUITD_C5 = 3'h5;
  localparam logic [2:0] CPUITD_C6 = 3'h6;
  // opcodes the timing sequencer or address logic look at
  localparam logic [7:0] CPUITD_OP_EXTERNAL_DATA_RAM_WR = 8'hf0;
  localparam logic [7:0] CPUITD_OP_EXTERNAL_DATA_RAM_RD = 8'he0;
  // direct address split between internal ram and special registers
  localparam int CPUITD_SFR_BIT = 7;
  // absolute targets keep the upper pc bits of an 11-bit page
  localparam int CPUITD_PAGE_BITS = 11;
  // bank register and pointer register field positions
  localparam int CPUITD_BANK_LSB = 3;
  localparam logic [2:0] CPUITD_PTR_NIBBLE = 3'h3;
  // reset values
  localparam logic [15:0] CPUITD_ADDR_RST = 16'h0000;
  localparam logic [7:0] CPUITD_BYTE_RST = 8'h00;
endpackage
`default_nettype wire

// ---- cpuitd_timer.sv ----
// down counter that holds off the next fetch for an instruction's cycle count
`default_nettype none
module cpuitd_timer
  import cpuitd_pkg::*;
#(
  parameter int CYC_W = CPUITD_CYC_W
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [CYC_W-1:0] load_val,
  output logic expire
);
  logic [CYC_W-1:0] remain;

  // loaded with the cycles still owed after the accepting edge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      remain <= '0;
    else if (load)
      remain <= CYC_W'(load_val - CYC_W'(1));
    else if (remain != '0)
      remain <= CYC_W'(remain - CYC_W'(1));
  end

  // last owed cycle: the sequencer may reopen fetch now
  assign expire = (remain == CYC_W'(1));
endmodule
`default_nettype wire

// ---- cpuitd_top.sv ----
// instruction length, cycle timing and fetch sequencing for the core
//
// Operation
// - every standard opcode of the architecture decodes with its usual encoding.
// - add, add_with_carry, subtract_with_borrow, and, or, xor with bank register: 1 byte, 1 cycle.
// - accumulator ops with direct byte operand: 2 bytes, 2 cycles.
// - accumulator ops with pointer-addressed ram: 1 byte, 2 cycles.
// - accumulator ops with immediate constant: 2 bytes, 2 cycles.
// - and, or, xor of accumulator into direct byte: 2 bytes, 3 cycles.
// - and, or, xor of immediate into direct byte: 3 bytes, 3 cycles.
// - accumulator-only and carry clear/set/complement ops: 1 byte, 1 cycle.
// - and/or of direct bit or its complement into carry: 2 bytes, 2 cycles.
// - copy direct bit into carry: 2 bytes, 2 cycles.
// - copy carry into direct bit: 2 bytes, 3 cycles.
// - move bank register to accumulator: 1 byte, 1 cycle.
// - move direct byte to accumulator: 2 bytes, 2 cycles.
// - read external ram through data pointer pair: 1 byte, 2 cycles.
// - write external ram by pointer pair: 3 cycles internal code to external_data_ram, else 4.
// - push direct byte: 2 bytes, 3 cycles.
// - pop into direct byte: 2 bytes, 2 cycles.
// - low nibble exchange with pointer-addressed ram: 1 byte, 3 cycles.
// - bank register operand picks one of eight in the selected bank.
// - relative operand is signed 8-bit offset from next instruction.
// - direct address below 0x80 is internal ram, otherwise special registers.
// - absolute target stays inside the 2 kB page of next instruction.
`default_nettype none
module cpuitd_top
  import cpuitd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1,
  input wire logic [7:0] operand2,
  input wire logic [15:0] instr_addr,
  input wire logic [1:0] bank_sel,
  input wire logic code_internal,
  input wire logic dest_external_data_ram,
  output logic instr_ready,
  output logic dec_valid,
  output logic [1:0] dec_len,
  output logic [2:0] dec_cycles,
  output logic dec_uses_bank,
  output logic dec_uses_ptr,
  output logic [15:0] next_pc,
  output logic [15:0] rel_target,
  output logic [15:0] abs_target,
  output logic [7:0] bank_reg_addr,
  output logic [7:0] ptr_reg_addr,
  output logic [7:0] direct_addr,
  output logic direct_is_sfr
);
  typedef enum logic [1:0] {
    CPUITD_IDLE = 2'b01,
    CPUITD_BUSY = 2'b10
  } cpuitd_state_e;

  // length and cycle count of one opcode
  function automatic logic [4:0] cpuitd_lookup(input logic [7:0] op, input logic fast_wr);
    logic [4:0] r;
    r = {CPUITD_L1, CPUITD_C1};
    casez (op)
      8'h00: r = {CPUITD_L1, CPUITD_C1};
      8'b???00001: r = {CPUITD_L2, CPUITD_C3};
      8'b???10001: r = {CPUITD_L2, CPUITD_C4};
      8'h02, 8'h12: r = {CPUITD_L3, CPUITD_C4};
      8'h22, 8'h32: r = {CPUITD_L1, CPUITD_C4};
      8'h10, 8'h20, 8'h30: r = {CPUITD_L3, CPUITD_C5};
      8'h40, 8'h50, 8'h80: r = {CPUITD_L2, CPUITD_C3};
      8'h60, 8'h70: r = {CPUITD_L2, CPUITD_C4};
      8'h03, 8'h13, 8'h23, 8'h33, 8'hc4, 8'he4, 8'hf4: r = {CPUITD_L1, CPUITD_C1};
      8'hc3, 8'hd3, 8'hb3: r = {CPUITD_L1, CPUITD_C1};
      8'h04, 8'h14, 8'ha3, 8'ha5: r = {CPUITD_L1, CPUITD_C1};
      8'h05, 8'h15, 8'hb2, 8'hc2, 8'hd2: r = {CPUITD_L2, CPUITD_C3};
      8'h42, 8'h52, 8'h62: r = {CPUITD_L2, CPUITD_C3};
      8'h43, 8'h53, 8'h63: r = {CPUITD_L3, CPUITD_C3};
      8'h75, 8'h85, 8'h90: r = {CPUITD_L3, CPUITD_C3};
      8'h24, 8'h34, 8'h94, 8'h44, 8'h54, 8'h64: r = {CPUITD_L2, CPUITD_C2};
      8'h25, 8'h35, 8'h95, 8'h45, 8'h55, 8'h65: r = {CPUITD_L2, CPUITD_C2};
      8'h74, 8'hf5: r = {CPUITD_L2, CPUITD_C2};
      8'he5: r = {CPUITD_L2, CPUITD_C2};
      8'h72, 8'h82, 8'ha0, 8'hb0: r = {CPUITD_L2, CPUITD_C2};
      8'ha2: r = {CPUITD_L2, CPUITD_C2};
      8'h92: r = {CPUITD_L2, CPUITD_C3};
      8'hc0: r = {CPUITD_L2, CPUITD_C3};
      8'hd0: r = {CPUITD_L2, CPUITD_C2};
      8'hc5: r = {CPUITD_L2, CPUITD_C3};
      8'h83: r = {CPUITD_L1, CPUITD_C4};
      8'h73, 8'h93: r = {CPUITD_L1, CPUITD_C5};
      8'h84: r = {CPUITD_L1, CPUITD_C6};
      8'ha4: r = {CPUITD_L1, CPUITD_C2};
      8'hd4: r = {CPUITD_L1, CPUITD_C3};
      8'hb4: r = {CPUITD_L3, CPUITD_C4};
      8'hb5, 8'hd5: r = {CPUITD_L3, CPUITD_C5};
      8'he0: r = {CPUITD_L1, CPUITD_C2};
      8'hf0: r = fast_wr ? {CPUITD_L1, CPUITD_C3} : {CPUITD_L1, CPUITD_C4};
      8'b1110001?: r = {CPUITD_L1, CPUITD_C3};
      8'b1111001?: r = {CPUITD_L1, CPUITD_C4};
      // pointer-register column
      8'b000?011?, 8'b1100011?: r = {CPUITD_L1, CPUITD_C3};
      8'b1101011?: r = {CPUITD_L1, CPUITD_C3};
      8'b0010011?, 8'b0011011?, 8'b1001011?: r = {CPUITD_L1, CPUITD_C2};
      8'b010?011?, 8'b0110011?: r = {CPUITD_L1, CPUITD_C2};
      8'b111?011?: r = {CPUITD_L1, CPUITD_C2};
      8'b0111011?: r = {CPUITD_L2, CPUITD_C2};
      8'b1000011?, 8'b1010011?: r = {CPUITD_L2, CPUITD_C3};
      8'b1011011?: r = {CPUITD_L3, CPUITD_C5};
      // bank-register column
      8'b000?1???, 8'b11001???: r = {CPUITD_L1, CPUITD_C2};
      8'b00101???, 8'b00111???, 8'b10011???: r = {CPUITD_L1, CPUITD_C1};
      8'b010?1???, 8'b01101???: r = {CPUITD_L1, CPUITD_C1};
      8'b11101???: r = {CPUITD_L1, CPUITD_C1};
      8'b11111???: r = {CPUITD_L1, CPUITD_C1};
      8'b01111???, 8'b10001???: r = {CPUITD_L2, CPUITD_C2};
      8'b10101???: r = {CPUITD_L2, CPUITD_C3};
      8'b10111???: r = {CPUITD_L3, CPUITD_C4};
      8'b11011???: r = {CPUITD_L2, CPUITD_C4};
      default: r = {CPUITD_L1, CPUITD_C1};
    endcase
    return r;
  endfunction

  cpuitd_state_e state;
  cpuitd_state_e next_state;
  logic [4:0] look;
  logic [1:0] look_len;
  logic [2:0] look_cyc;
  logic accept;
  logic expire;
  logic fast_wr;
  logic ptr_op;
  logic next_ready;
  logic [15:0] a_next_pc;
  logic [15:0] a_rel;
  logic [15:0] a_abs;
  logic [7:0] a_bank;
  logic [7:0] a_ptr;

  // the short write path only exists for internal code writing external_data_ram
  assign fast_wr = code_internal & dest_external_data_ram;
  assign look = cpuitd_lookup(opcode, fast_wr);
  assign look_len = look[4:3];
  assign look_cyc = look[2:0];
  assign accept = instr_valid & instr_ready;
  // indirect column and the 8-bit external moves use R0/R1
  assign ptr_op = (opcode[3:1] == CPUITD_PTR_NIBBLE) | ((opcode[7:5] == 3'h7) & (opcode[3:1] == 3'h1));

  cpuitd_addr u_addr (
    .instr_addr(instr_addr),
    .instr_len(look_len),
    .opcode(opcode),
    .operand1(operand1),
    .operand2(operand2),
    .bank_sel(bank_sel),
    .next_pc(a_next_pc),
    .rel_target(a_rel),
    .abs_target(a_abs),
    .bank_reg_addr(a_bank),
    .ptr_reg_addr(a_ptr)
  );

  cpuitd_timer #(
    .CYC_W(CPUITD_CYC_W)
  ) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(accept),
    .load_val(look_cyc),
    .expire(expire)
  );

  // one-cycle instructions keep fetch open; longer ones hold it shut
  always_comb
  begin
    next_state = state;
    next_ready = instr_ready;
    unique case (state)
      CPUITD_IDLE:
      begin
        if (accept && (look_cyc != CPUITD_C1))
        begin
          next_state = CPUITD_BUSY;
          next_ready = 1'b0;
        end
      end
      CPUITD_BUSY:
      begin
        if (expire)
        begin
          next_state = CPUITD_IDLE;
          next_ready = 1'b1;
        end
      end
      default:
      begin
        next_state = CPUITD_IDLE;
        next_ready = 1'b1;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state <= CPUITD_IDLE;
      instr_ready <= 1'b1;
      dec_valid <= 1'b0;
    end
    else
    begin
      state <= next_state;
      instr_ready <= next_ready;
      dec_valid <= accept;
    end
  end

  // decoded fields hold until the next accepted opcode
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dec_len <= CPUITD_L1;
      dec_cycles <= CPUITD_C1;
      dec_uses_bank <= 1'b0;
      dec_uses_ptr <= 1'b0;
      next_pc <= CPUITD_ADDR_RST;
      rel_target <= CPUITD_ADDR_RST;
      abs_target <= CPUITD_ADDR_RST;
      bank_reg_addr <= CPUITD_BYTE_RST;
      ptr_reg_addr <= CPUITD_BYTE_RST;
      direct_addr <= CPUITD_BYTE_RST;
      direct_is_sfr <= 1'b0;
    end
    else if (accept)
    begin
      dec_len <= look_len;
      dec_cycles <= look_cyc;
      dec_uses_bank <= opcode[CPUITD_BANK_LSB];
      dec_uses_ptr <= ptr_op;
      next_pc <= a_next_pc;
      rel_target <= a_rel;
      abs_target <= a_abs;
      bank_reg_addr <= a_bank;
      ptr_reg_addr <= a_ptr;
      direct_addr <= operand1;
      direct_is_sfr <= operand1[CPUITD_SFR_BIT];
    end
  end

  // checks next to the sequencer
  AST_GAP_ONE: assert property (@(posedge clk) disable iff (sys_rst)
    accept && look_cyc == CPUITD_C1 |=> instr_ready)
    else $error("one-cycle instruction closed fetch");
  AST_GAP_THREE: assert property (@(posedge clk) disable iff (sys_rst)
    accept && look_cyc == CPUITD_C3 |=> !instr_ready ##1 !instr_ready ##1 instr_ready)
    else $error("three-cycle instruction spacing wrong");
  AST_GAP_SIX: assert property (@(posedge clk) disable iff (sys_rst)
    accept && look_cyc == CPUITD_C6 |=> !instr_ready [*5] ##1 instr_ready)
    else $error("six-cycle instruction spacing wrong");
  AST_BANK_ALU: assert property (@(posedge clk) disable iff (sys_rst)
    accept && opcode[7:3] == 5'h05 |=> dec_len == CPUITD_L1 && dec_cycles == CPUITD_C1 && dec_valid)
    else $error("bank register add timing wrong");
  AST_DIRECT_ALU: assert property (@(posedge clk) disable iff (sys_rst)
    accept && opcode == 8'h55 |=> dec_len == CPUITD_L2 && dec_cycles == CPUITD_C2)
    else $error("direct operand and timing wrong");
  AST_IMM_TO_DIRECT: assert property (@(posedge clk) disable iff (sys_rst)
    accept && opcode == 8'h63 |=> dec_len == CPUITD_L3 ##1 !instr_ready ##1 instr_ready)
    else $error("immediate to direct xor timing wrong");
  AST_EXTERNAL_DATA_RAM_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    accept && opcode == CPUITD_OP_EXTERNAL_DATA_RAM_WR |=> dec_cycles == ($past(fast_wr) ? CPUITD_C3 : CPUITD_C4))
    else $error("external write cycle count wrong");
  AST_EXTERNAL_DATA_RAM_READ: assert property (@(posedge clk) disable iff (sys_rst)
    accept && opcode == CPUITD_OP_EXTERNAL_DATA_RAM_RD |=> !instr_ready ##1 instr_ready)
    else $error("external read spacing wrong");
  AST_SFR_SPLIT: assert property (@(posedge clk) disable iff (sys_rst)
    accept |=> direct_addr == $past(operand1) && direct_is_sfr == ($past(operand1) >= 8'h80))
    else $error("direct space split wrong");
  AST_PAGE: assert property (@(posedge clk) disable iff (sys_rst)
    accept |=> abs_target[15:11] == next_pc[15:11] && abs_target[10:0] == {$past(opcode[7:5]), $past(operand1)})
    else $error("absolute target left its page");
  AST_BANK_ADDR: assert property (@(posedge clk) disable iff (sys_rst)
    accept |=> bank_reg_addr == {3'h0, $past(bank_sel), $past(opcode[2:0])})
    else $error("bank register address wrong");
  AST_NEXT_PC: assert property (@(posedge clk) disable iff (sys_rst)
    accept |=> next_pc == 16'($past(instr_addr) + {14'h0000, dec_len}))
    else $error("following instruction address wrong");

  // decode table spot checks, one opcode or opcode group per timing row
  AST_POINTER_ALU: assert property (@(posedge clk) disable iff (sys_rst)
    accept && opcode == 8'h26 |=> dec_len == CPUITD_L1 && dec_cycles == CPUITD_C2 && !instr_ready ##1 instr_ready)
    else $error("pointer operand timing wrong");
  AST_IMM_ALU: assert property (@(posedge clk) disable iff (sys_rst)
    accept && opcode == 8'h24 |=> dec_len == CPUITD_L2 && dec_cycles == CPUITD_C2)
    else $error("immediate operand timing wrong");
  AST_DIRECT_FROM_ACC: assert property (@(posedge clk) disable iff (sys_rst)
    accept && opcode == 8'h52 |=> dec_len == CPUITD_L2 && dec_cycles == CPUITD_C3 ##1 !instr_ready ##1 instr_ready)
    else $error("accumulator into direct timing wrong");
  AST_ACC_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
    accept && opcode == 8'he4 |=> dec_len == CPUITD_L1 && dec_cycles == CPUITD_C1 && instr_ready)
    else $error("accumulator-only timing wrong");
  AST_BIT_CARRY: assert property (@(posedge clk) disable iff (sys_rst)
    accept && opcode == 8'h82 |=> dec_len == CPUITD_L2 && dec_cycles == CPUITD_C2)
    else $error("bit into carry logic timing wrong");
  AST_BIT_TO_CARRY: assert property (@(posedge clk) disable iff (sys_rst)
    accept && opcode == 8'ha2 |=> dec_len == CPUITD_L2 && dec_cycles == CPUITD_C2)
    else $error("bit copy into carry timing wrong");
  AST_CARRY_TO_BIT: assert property (@(posedge clk) disable iff (sys_rst)
    accept && opcode == 8'h92 |=> dec_len == CPUITD_L2 && dec_cycles == CPUITD_C3)
    else $error("carry copy into bit timing wrong");
  AST_MOVE_BANK: assert property (@(posedge clk) disable iff (sys_rst)
    accept && opcode[7:3] == 5'h1d |=> dec_len == CPUITD_L1 && dec_cycles == CPUITD_C1)
    else $error("bank register move timing wrong");
  AST_MOVE_DIRECT: assert property (@(posedge clk) disable iff (sys_rst)
    accept && opcode == 8'he5 |=> dec_len == CPUITD_L2 && dec_cycles == CPUITD_C2)
    else $error("direct move timing wrong");
  AST_PUSH: assert property (@(posedge clk) disable iff (sys_rst)
    accept && opcode == 8'hc0 |=> dec_len == CPUITD_L2 && dec_cycles == CPUITD_C3)
    else $error("push timing wrong");
  AST_POP: assert property (@(posedge clk) disable iff (sys_rst)
    accept && opcode == 8'hd0 |=> dec_len == CPUITD_L2 && dec_cycles == CPUITD_C2)
    else $error("pop timing wrong");
  AST_XCH_DIRECT: assert property (@(posedge clk) disable iff (sys_rst)
    accept && opcode == 8'hc5 |=> dec_len == CPUITD_L2 && dec_cycles == CPUITD_C3)
    else $error("direct exchange timing wrong");
  AST_NIBBLE_XCH: assert property (@(posedge clk) disable iff (sys_rst)
    accept && opcode[7:1] == 7'h6b |=> dec_len == CPUITD_L1 && dec_cycles == CPUITD_C3)
    else $error("low nibble exchange timing wrong");

  // sequencer bookkeeping: ready, state and timer must agree
  AST_READY_STATE: assert property (@(posedge clk) disable iff (sys_rst)
    instr_ready == (state == CPUITD_IDLE))
    else $error("fetch ready disagrees with sequencer state");
  AST_NO_TAKE_BUSY: assert property (@(posedge clk) disable iff (sys_rst)
    !instr_ready |=> !dec_valid)
    else $error("opcode taken while fetch was shut");
  AST_EXPIRE_BUSY: assert property (@(posedge clk) disable iff (sys_rst)
    expire |-> state == CPUITD_BUSY)
    else $error("timer expired outside a busy span");
endmodule
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the instruction length and timing decoder
`default_nettype none
module testbench
  import cpuitd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic instr_valid = 1'b0;
  logic code_internal = 1'b0;
  logic dest_external_data_ram = 1'b0;
  logic [15:0] instr_addr = 16'h0000;
  logic [1:0] bank_sel = 2'h0;
  logic [7:0] opcode, operand1, operand2, bank_reg_addr, ptr_reg_addr, direct_addr;
  logic instr_ready, dec_valid, dec_uses_bank, dec_uses_ptr, direct_is_sfr;
  logic [1:0] dec_len;
  logic [2:0] dec_cycles;
  logic [15:0] next_pc, rel_target, abs_target;
  int errors = 0;
  int checks = 0;
  logic [7:0] alu_col [0:5] = '{8'h20, 8'h30, 8'h90, 8'h50, 8'h40, 8'h60};
  logic [7:0] acc_ops [0:9] = '{8'he4, 8'hf4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4, 8'hc3, 8'hd3, 8'hb3};
  logic [7:0] bit_ops [0:3] = '{8'h82, 8'hb0, 8'h72, 8'ha0};

  cpuitd_code_mem cpuitd_code_mem_inst (.fetch_addr(instr_addr), .rd_en(instr_valid), .byte0(opcode),
    .byte1(operand1), .byte2(operand2));
  cpuitd_top cpuitd_top_inst (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .opcode(opcode),
    .operand1(operand1), .operand2(operand2), .instr_addr(instr_addr), .bank_sel(bank_sel),
    .code_internal(code_internal), .dest_external_data_ram(dest_external_data_ram), .instr_ready(instr_ready), .dec_valid(dec_valid),
    .dec_len(dec_len), .dec_cycles(dec_cycles), .dec_uses_bank(dec_uses_bank), .dec_uses_ptr(dec_uses_ptr),
    .next_pc(next_pc), .rel_target(rel_target), .abs_target(abs_target), .bank_reg_addr(bank_reg_addr),
    .ptr_reg_addr(ptr_reg_addr), .direct_addr(direct_addr), .direct_is_sfr(direct_is_sfr));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one instruction: load code bytes, hand it over, judge decode and busy span
  task automatic run_instr(input logic [7:0] op, input logic [7:0] o1, input logic [15:0] addr,
    input logic [1:0] len, input logic [2:0] cyc);
    int n;
    n = 0;
    cpuitd_code_mem_inst.mem[addr] = op;
    cpuitd_code_mem_inst.mem[addr + 16'h0001] = o1;
    cpuitd_code_mem_inst.mem[addr + 16'h0002] = 8'h5a;
    while (instr_ready !== 1'b1 && n < 10)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check("ready_wait", {15'h0, instr_ready}, 16'h0001);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_addr <= addr;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    check("dec_valid", {15'h0, dec_valid}, 16'h0001);
    check("dec_len", {14'h0, dec_len}, {14'h0, len});
    check("dec_cycles", {13'h0, dec_cycles}, {13'h0, cyc});
    check("next_pc", next_pc, addr + {14'h0, len});
    n = 0;
    while (instr_ready === 1'b0 && n < 10)
    begin
      n++;
      @(posedge clk);
      #1;
    end
    check("busy_cycles", n[15:0], {13'h0, cyc} - 16'h0001);
  endtask

  task automatic scen_alu;
    for (int i = 0; i < 6; i++)
    begin
      run_instr(alu_col[i] + 8'h08 + 8'(i), 8'h00, 16'h0100, CPUITD_L1, CPUITD_C1);
      run_instr(alu_col[i] + 8'h05, 8'h30, 16'h0100, CPUITD_L2, CPUITD_C2);
      run_instr(alu_col[i] + 8'h06, 8'h00, 16'h0100, CPUITD_L1, CPUITD_C2);
      run_instr(alu_col[i] + 8'h04, 8'h11, 16'h0100, CPUITD_L2, CPUITD_C2);
      if (i >= 3)
      begin
        run_instr(alu_col[i] + 8'h02, 8'h30, 16'h0100, CPUITD_L2, CPUITD_C3);
        run_instr(alu_col[i] + 8'h03, 8'h30, 16'h0100, CPUITD_L3, CPUITD_C3);
      end
    end
  endtask

  task automatic scen_acc_bit;
    for (int i = 0; i < 10; i++)
      run_instr(acc_ops[i], 8'h00, 16'h0100, CPUITD_L1, CPUITD_C1);
    for (int i = 0; i < 4; i++)
      run_instr(bit_ops[i], 8'h21, 16'h0100, CPUITD_L2, CPUITD_C2);
    run_instr(8'ha2, 8'h21, 16'h0100, CPUITD_L2, CPUITD_C2);
    run_instr(8'h92, 8'h21, 16'h0100, CPUITD_L2, CPUITD_C3);
  endtask

  task automatic scen_move;
    run_instr(8'he9, 8'h00, 16'h0100, CPUITD_L1, CPUITD_C1);
    run_instr(8'he5, 8'h30, 16'h0100, CPUITD_L2, CPUITD_C2);
    run_instr(8'he0, 8'h00, 16'h0100, CPUITD_L1, CPUITD_C2);
    run_instr(8'hc0, 8'h30, 16'h0100, CPUITD_L2, CPUITD_C3);
    run_instr(8'hd0, 8'h30, 16'h0100, CPUITD_L2, CPUITD_C2);
    run_instr(8'hc5, 8'h30, 16'h0100, CPUITD_L2, CPUITD_C3);
    run_instr(8'hd6, 8'h00, 16'h0100, CPUITD_L1, CPUITD_C3);
    run_instr(8'h84, 8'h00, 16'h0100, CPUITD_L1, CPUITD_C6);
    // every pairing of code source and destination for the external write
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      code_internal <= i[1];
      dest_external_data_ram <= i[0];
      run_instr(CPUITD_OP_EXTERNAL_DATA_RAM_WR, 8'h00, 16'h0100, CPUITD_L1, (i == 3) ? CPUITD_C3 : CPUITD_C4);
    end
  endtask

  task automatic scen_addr;
    @(posedge clk);
    bank_sel <= 2'h2;
    run_instr(8'h2b, 8'h00, 16'h0100, CPUITD_L1, CPUITD_C1);
    check("bank_reg_addr", {8'h00, bank_reg_addr}, 16'h0013);
    check("bank_use", {14'h0, dec_uses_bank, dec_uses_ptr}, 16'h0002);
    run_instr(8'h27, 8'h00, 16'h0100, CPUITD_L1, CPUITD_C2);
    check("ptr_reg_addr", {8'h00, ptr_reg_addr}, 16'h0011);
    check("ptr_use", {14'h0, dec_uses_bank, dec_uses_ptr}, 16'h0001);
    run_instr(8'hf3, 8'h00, 16'h0100, CPUITD_L1, CPUITD_C4);
    check("ext_ptr_use", {14'h0, dec_uses_bank, dec_uses_ptr}, 16'h0001);
    run_instr(8'h25, 8'h7f, 16'h0100, CPUITD_L2, CPUITD_C2);
    check("ram_direct", {7'h00, direct_is_sfr, direct_addr}, 16'h007f);
    run_instr(8'h25, 8'h80, 16'h0100, CPUITD_L2, CPUITD_C2);
    check("sfr_direct", {7'h00, direct_is_sfr, direct_addr}, 16'h0180);
    run_instr(8'h80, 8'hfe, 16'h1000, CPUITD_L2, CPUITD_C3);
    check("rel_back", rel_target, 16'h1000);
    run_instr(8'h80, 8'h7f, 16'h1000, CPUITD_L2, CPUITD_C3);
    check("rel_fwd", rel_target, 16'h1081);
    check("dec_valid_drop", {15'h0, dec_valid}, 16'h0000);
    // jump sitting at a page end lands in the following page
    run_instr(8'h21, 8'h34, 16'h07fe, CPUITD_L2, CPUITD_C3);
    check("abs_target", abs_target, 16'h0934);
  endtask

  // reset landing in the middle of a long instruction frees the fetch at once
  task automatic scen_abort;
    cpuitd_code_mem_inst.mem[16'h0200] = CPUITD_OP_EXTERNAL_DATA_RAM_WR;
    @(posedge clk);
    code_internal <= 1'b0;
    instr_valid <= 1'b1;
    instr_addr <= 16'h0200;
    @(posedge clk);
    instr_valid <= 1'b0;
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check("ready_after_rst", {15'h0, instr_ready}, 16'h0001);
    check("valid_after_rst", {15'h0, dec_valid}, 16'h0000);
    check("cycles_after_rst", {13'h0, dec_cycles}, {13'h0, CPUITD_C1});
  endtask

  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    check("ready_reset", {15'h0, instr_ready}, 16'h0001);
    scen_alu;
    scen_acc_bit;
    scen_move;
    scen_addr;
    scen_abort;
    report_and_stop;
  end

  // watchdog, far beyond the few hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
